// ===== hdl/egc_pkg.sv
// Types shared by the gear/cam block.
// Assumes egc_regs.svh is on the include path.
package egc_pkg;
  typedef logic signed [31:0] egc_pos_t;
  typedef logic signed [63:0] egc_fine_t;
  typedef logic        [8:0]  egc_idx_t;
endpackage

// ===== hdl/egc_regs.svh
// Register map, field positions, reset values and limits of the gear/cam block.
// Assumes 32-bit Wishbone data with byte addresses, one word per register.
`ifndef EGC_REGS_SVH
`define EGC_REGS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define EGC_CTRL_OFS        8'h00
`define EGC_GEAR_RATIO_OFS  8'h04
`define EGC_RAMP_DIST_OFS   8'h08
`define EGC_PHASE_LAG_OFS   8'h0c
`define EGC_CAM_MCYC_OFS    8'h10
`define EGC_CAM_SCYC_OFS    8'h14
`define EGC_CAM_INTV_OFS    8'h18
`define EGC_CAM_PHASE_OFS   8'h1c
`define EGC_CAM_IDX_OFS     8'h20
`define EGC_CAM_ENTRY_OFS   8'h24
`define EGC_CAM_ENGAGE_OFS  8'h28
`define EGC_CAM_DISENG_OFS  8'h2c
`define EGC_TRIP_REV_OFS    8'h30
`define EGC_TRIP_FWD_OFS    8'h34
`define EGC_STATUS_OFS      8'h38
`define EGC_SLAVE_REF_OFS   8'h3c
`define EGC_CAM_MPOS_OFS    8'h40
`define EGC_CAM_SPOS_OFS    8'h44
// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define EGC_CTRL_GEAR_SEL   0
`define EGC_CTRL_GANTRY     1
`define EGC_CTRL_CAM_SEL    2
`define EGC_CTRL_CAM_EN     3
`define EGC_ST_GEAR_ON      0
`define EGC_ST_RAMPING      1
`define EGC_ST_CAM_ENG      2
`define EGC_ST_ENG_ARMED    3
`define EGC_ST_DIS_ARMED    4
`define EGC_ST_TRIP_REV     5
`define EGC_ST_TRIP_FWD     6
// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define EGC_CTRL_RST        32'h0000_0000
`define EGC_RATIO_ONE       32'sd10000
`define EGC_RATIO_MAX       32'sd1279999
`define EGC_MCYC_MAX        32'h007f_ffff
`define EGC_SCYC_MAX        32'h7fff_ffff
`define EGC_MCYC_RST        32'h0000_0001
`define EGC_INTV_RST        32'h0000_0001
`define EGC_TAB_LAST        256
`endif

// ===== hdl/egc_top.sv
// Electronic gearing and electronic cam position reference generator.
// Assumes master positions arrive as absolute counts, sampled on sample_tick_i,
// and that the master moves less than one cam cycle per sample.
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "egc_regs.svh"

module egc_top (
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  input  wire logic           sample_tick_i,
  input  wire egc_pkg::egc_pos_t aux_enc_pos_i,
  input  wire egc_pkg::egc_pos_t virt_pos_i,
  input  wire egc_pkg::egc_pos_t move_incr_i,
  input  wire logic           limit_hit_i,
  input  wire logic           stop_command_i,
  output egc_pkg::egc_pos_t   slave_ref_o,
  output logic                trip_hold_o
);
  import egc_pkg::*;

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic        ack_q;
  logic        req;
  logic        wr_en;
  assign req      = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack high
  assign wr_en    = req & wb_we_i & ack_q;
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) ack_q <= 1'b0;
    else ack_q <= req & ~ack_q;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  logic [31:0] wv;
  assign wv = merge(32'h0, wb_dat_i, wb_sel_i);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q;
  egc_pos_t    ramp_dist_q;
  logic [31:0] mcyc_q;
  logic [31:0] scyc_q;
  logic [31:0] intv_q;
  logic [31:0] phase_q;
  egc_idx_t    tab_idx_q;
  egc_pos_t    eng_pt_q;
  egc_pos_t    dis_pt_q;
  egc_pos_t    trip_rev_val_q;
  egc_pos_t    trip_fwd_val_q;
  egc_pos_t    tab [0:`EGC_TAB_LAST];
  logic        wr_ratio;
  egc_pos_t    ratio_wr;
  assign wr_ratio = wr_en && wb_adr_i == `EGC_GEAR_RATIO_OFS;
  assign ratio_wr = (wv[31] && $signed(wv) < -`EGC_RATIO_MAX) ? -`EGC_RATIO_MAX :
                    (!wv[31] && $signed(wv) > `EGC_RATIO_MAX) ? `EGC_RATIO_MAX : $signed(wv);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q         <= `EGC_CTRL_RST;
      ramp_dist_q    <= '0;
      mcyc_q         <= `EGC_MCYC_RST;
      scyc_q         <= '0;
      intv_q         <= `EGC_INTV_RST;
      phase_q        <= '0;
      tab_idx_q      <= '0;
      eng_pt_q       <= '0;
      dis_pt_q       <= '0;
      trip_rev_val_q <= '0;
      trip_fwd_val_q <= '0;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        `EGC_CTRL_OFS:       ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_000f;
        `EGC_RAMP_DIST_OFS:  ramp_dist_q <= (wv[31]) ? -$signed(wv) : $signed(wv);
        `EGC_CAM_MCYC_OFS:   mcyc_q <= (wv == 32'h0) ? `EGC_MCYC_RST :
                                       (wv > `EGC_MCYC_MAX) ? `EGC_MCYC_MAX : wv;
        `EGC_CAM_SCYC_OFS:   scyc_q <= wv & `EGC_SCYC_MAX;
        `EGC_CAM_INTV_OFS:   intv_q <= (wv == 32'h0) ? `EGC_INTV_RST : wv;
        `EGC_CAM_PHASE_OFS:  phase_q <= wv;
        `EGC_CAM_IDX_OFS:    tab_idx_q <= (wv > 32'd`EGC_TAB_LAST) ? 9'd`EGC_TAB_LAST : wv[8:0];
        `EGC_CAM_ENGAGE_OFS: eng_pt_q <= $signed(wv);
        `EGC_CAM_DISENG_OFS: dis_pt_q <= $signed(wv);
        `EGC_TRIP_REV_OFS:   trip_rev_val_q <= $signed(wv);
        `EGC_TRIP_FWD_OFS:   trip_fwd_val_q <= $signed(wv);
        default: ;
      endcase
    end
  end

  // Table storage has no reset; software loads it before enabling the cam
  always_ff @(posedge clk_i) begin
    if (wr_en && wb_adr_i == `EGC_CAM_ENTRY_OFS) tab[tab_idx_q] <= $signed(wv);
  end

  // --------------------------------------------------------------------------
  // Master deltas
  // --------------------------------------------------------------------------
  egc_pos_t prev_aux_q;
  egc_pos_t prev_virt_q;
  egc_pos_t d_gear;
  egc_pos_t d_cam;
  egc_pos_t d_gear_abs;
  assign d_gear = ctrl_q[`EGC_CTRL_GEAR_SEL] ? virt_pos_i - prev_virt_q : aux_enc_pos_i - prev_aux_q;
  assign d_cam  = ctrl_q[`EGC_CTRL_CAM_SEL] ? virt_pos_i - prev_virt_q : aux_enc_pos_i - prev_aux_q;
  assign d_gear_abs = d_gear[31] ? -d_gear : d_gear;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_aux_q  <= '0;
      prev_virt_q <= '0;
    end else if (sample_tick_i) begin
      prev_aux_q  <= aux_enc_pos_i;
      prev_virt_q <= virt_pos_i;
    end
  end

  // --------------------------------------------------------------------------
  // Electronic gearing with ramped ratio
  // --------------------------------------------------------------------------
  logic      gear_on_q;
  logic      ramping_q;
  egc_pos_t  eff_q;
  egc_pos_t  target_q;
  egc_pos_t  step_q;
  egc_fine_t gear_fine_q;
  egc_fine_t lag_fine_q;
  egc_pos_t  step_new;
  egc_fine_t eff_adv;
  egc_fine_t eff_next;
  logic      ramp_done;
  logic      gear_drop;

  // Divider runs all the time; its result is taken only on ratio writes and kept in step_q
  always_comb begin
    step_new = (target_diff(ratio_wr, eff_q)) / ramp_dist_q;
    if (step_new == '0) step_new = (ratio_wr < eff_q) ? -32'sd1 : 32'sd1;
  end

  function automatic egc_pos_t target_diff(input egc_pos_t a, input egc_pos_t b);
    return a - b;
  endfunction

  assign eff_adv   = 64'(step_q) * 64'(d_gear_abs);
  assign eff_next  = 64'(eff_q) + eff_adv;
  assign ramp_done = (step_q[31] && eff_next <= 64'(target_q)) || (!step_q[31] && eff_next >= 64'(target_q));
  assign gear_drop = (limit_hit_i | stop_command_i) & ~ctrl_q[`EGC_CTRL_GANTRY];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gear_on_q <= 1'b0;
      ramping_q <= 1'b0;
      eff_q     <= '0;
      target_q  <= '0;
      step_q    <= '0;
    end else if (wr_ratio) begin
      target_q  <= ratio_wr;
      gear_on_q <= ratio_wr != '0;
      if (ratio_wr == '0 || ramp_dist_q == '0) begin
        eff_q     <= ratio_wr;
        ramping_q <= 1'b0;
      end else begin
        step_q    <= step_new;
        ramping_q <= 1'b1;
      end
    end else if (gear_drop) begin
      gear_on_q <= 1'b0;
      ramping_q <= 1'b0;
      eff_q     <= '0;
      target_q  <= '0;
    end else if (sample_tick_i && ramping_q) begin
      eff_q     <= ramp_done ? target_q : eff_next[31:0];
      ramping_q <= ~ramp_done;
    end
  end

  // Fine accumulators hold counts times ten thousand so no fraction is lost
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gear_fine_q <= '0;
      lag_fine_q  <= '0;
    end else if (sample_tick_i && gear_on_q) begin
      gear_fine_q <= gear_fine_q + 64'(d_gear) * 64'(eff_q);
      lag_fine_q  <= lag_fine_q + 64'(d_gear) * 64'(target_q - eff_q);
    end
  end

  egc_pos_t gear_cnt;
  egc_pos_t lag_cnt;
  assign gear_cnt = 32'(gear_fine_q / 64'(`EGC_RATIO_ONE));
  assign lag_cnt  = 32'(lag_fine_q / 64'(`EGC_RATIO_ONE));

  gear_ratio_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    eff_q <= `EGC_RATIO_MAX && eff_q >= -`EGC_RATIO_MAX)
    else $error("effective ratio out of range");
  gear_zero_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ratio && ratio_wr == '0 |=> !gear_on_q && eff_q == '0)
    else $error("zero ratio left gearing on");
  gantry_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    gear_on_q && ctrl_q[`EGC_CTRL_GANTRY] && !wr_ratio && (limit_hit_i || stop_command_i) |=> gear_on_q)
    else $error("gantry gearing dropped");
  gear_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_ratio && !ctrl_q[`EGC_CTRL_GANTRY] && (limit_hit_i || stop_command_i) |=> !gear_on_q)
    else $error("gearing kept through stop");
  ramp_sync_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ramping_q && !$past(wr_ratio) && !$past(gear_drop) |-> eff_q == target_q)
    else $error("ratio not synchronised after ramp");

  // --------------------------------------------------------------------------
  // Electronic cam
  // --------------------------------------------------------------------------
  logic      cam_eng_q;
  logic      eng_armed_q;
  logic      dis_armed_q;
  egc_pos_t  u_q;
  egc_pos_t  cam_base_q;
  egc_pos_t  cam_pos_q;
  egc_pos_t  u_sum;
  egc_pos_t  u_next;
  egc_pos_t  x_pos;
  egc_pos_t  seg_idx;
  egc_pos_t  seg_off;
  egc_idx_t  i0;
  egc_idx_t  i1;
  egc_pos_t  y_pos;
  egc_pos_t  y_mod;
  logic      wrap_fwd;
  logic      wrap_rev;
  logic      eng_hit;
  logic      dis_hit;
  logic      cam_en;
  assign cam_en   = ctrl_q[`EGC_CTRL_CAM_EN];
  assign u_sum    = u_q + d_cam;
  assign wrap_fwd = u_sum >= $signed(mcyc_q);
  assign wrap_rev = u_sum[31];
  assign u_next   = wrap_fwd ? u_sum - $signed(mcyc_q) : wrap_rev ? u_sum + $signed(mcyc_q) : u_sum;

  always_comb begin
    x_pos = u_q - $signed(phase_q);
    if (x_pos[31]) x_pos = x_pos + $signed(mcyc_q);
    seg_idx = x_pos / $signed(intv_q);
    seg_off = x_pos - seg_idx * $signed(intv_q);
    i0 = (seg_idx >= `EGC_TAB_LAST) ? 9'(`EGC_TAB_LAST - 1) : seg_idx[8:0];
    i1 = i0 + 9'h001;
    // Divisor kept signed so a falling segment does not turn the quotient unsigned
    y_pos = tab[i0] + 32'((64'(tab[i1] - tab[i0]) * 64'(seg_off)) / 64'($signed(intv_q)));
    y_mod = (y_pos >= $signed(scyc_q) && scyc_q != '0) ? y_pos - $signed(scyc_q) : y_pos;
  end

  function automatic logic crossed(input egc_pos_t p, input egc_pos_t a, input egc_pos_t b);
    return (a < p && p <= b) || (b <= p && p < a);
  endfunction

  // Crossing checks ignore the wrapped sample to avoid a false hit across zero
  assign eng_hit = eng_armed_q && sample_tick_i && !wrap_fwd && !wrap_rev && crossed(eng_pt_q, u_q, u_next);
  assign dis_hit = dis_armed_q && sample_tick_i && !wrap_fwd && !wrap_rev && crossed(dis_pt_q, u_q, u_next);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cam_eng_q   <= 1'b0;
      eng_armed_q <= 1'b0;
      dis_armed_q <= 1'b0;
    end else if (!cam_en) begin
      cam_eng_q   <= 1'b0;
      eng_armed_q <= 1'b0;
      dis_armed_q <= 1'b0;
    end else if (wr_en && wb_adr_i == `EGC_CAM_ENGAGE_OFS) begin
      if (wv[31] || wv >= mcyc_q) cam_eng_q <= 1'b1;
      else eng_armed_q <= 1'b1;
    end else if (wr_en && wb_adr_i == `EGC_CAM_DISENG_OFS) begin
      if (wv[31] || wv >= mcyc_q) cam_eng_q <= 1'b0;
      else dis_armed_q <= 1'b1;
    end else if (eng_hit) begin
      cam_eng_q   <= 1'b1;
      eng_armed_q <= 1'b0;
    end else if (dis_hit) begin
      cam_eng_q   <= 1'b0;
      dis_armed_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      u_q        <= '0;
      cam_base_q <= '0;
      cam_pos_q  <= '0;
    end else begin
      if (sample_tick_i && cam_en) begin
        u_q <= u_next;
      end
      if (cam_en && !cam_eng_q && (eng_hit || (wr_en && wb_adr_i == `EGC_CAM_ENGAGE_OFS))) begin
        cam_base_q <= cam_pos_q - y_mod;
      end else if (sample_tick_i && cam_eng_q) begin
        if (wrap_fwd) cam_base_q <= cam_base_q + $signed(scyc_q);
        else if (wrap_rev) cam_base_q <= cam_base_q - $signed(scyc_q);
        cam_pos_q <= cam_base_q + y_pos;
      end
    end
  end

  cam_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    u_q >= 0 && u_q < $signed(mcyc_q) || $changed(mcyc_q))
    else $error("cam master position left its cycle");
  cam_engage_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    eng_hit && cam_en && !(wr_en && (wb_adr_i == `EGC_CAM_ENGAGE_OFS || wb_adr_i == `EGC_CAM_DISENG_OFS))
    |=> cam_eng_q)
    else $error("cam did not engage at point");
  cam_disen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en && wb_adr_i == `EGC_CAM_DISENG_OFS && (wv[31] || wv >= mcyc_q) |=> !cam_eng_q)
    else $error("cam not stopped at once");
  cam_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cam_en |=> !cam_eng_q && !eng_armed_q)
    else $error("cam active while disabled");

  // --------------------------------------------------------------------------
  // Slave reference and trippoints
  // --------------------------------------------------------------------------
  egc_pos_t move_acc_q;
  egc_pos_t slave_q;
  logic     trip_rev_q;
  logic     trip_fwd_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      move_acc_q <= '0;
      slave_q    <= '0;
    end else if (sample_tick_i) begin
      move_acc_q <= move_acc_q + move_incr_i;
      slave_q    <= gear_cnt + cam_pos_q + move_acc_q;
    end
  end
  assign slave_ref_o = slave_q;

  // A new arm write wins over a pass detected in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trip_rev_q <= 1'b0;
      trip_fwd_q <= 1'b0;
    end else begin
      if (wr_en && wb_adr_i == `EGC_TRIP_REV_OFS) trip_rev_q <= 1'b1;
      else if (slave_q < trip_rev_val_q) trip_rev_q <= 1'b0;
      if (wr_en && wb_adr_i == `EGC_TRIP_FWD_OFS) trip_fwd_q <= 1'b1;
      else if (slave_q > trip_fwd_val_q) trip_fwd_q <= 1'b0;
    end
  end
  assign trip_hold_o = trip_rev_q | trip_fwd_q;

  trip_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    trip_fwd_q && slave_q > trip_fwd_val_q && !(wr_en && wb_adr_i == `EGC_TRIP_FWD_OFS) |=> !trip_fwd_q)
    else $error("forward trippoint not released");

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [31:0] rd;
  always_comb begin
    unique case (wb_adr_i)
      `EGC_CTRL_OFS:       rd = ctrl_q;
      `EGC_GEAR_RATIO_OFS: rd = target_q;
      `EGC_RAMP_DIST_OFS:  rd = ramp_dist_q;
      `EGC_PHASE_LAG_OFS:  rd = lag_cnt;
      `EGC_CAM_MCYC_OFS:   rd = mcyc_q;
      `EGC_CAM_SCYC_OFS:   rd = scyc_q;
      `EGC_CAM_INTV_OFS:   rd = intv_q;
      `EGC_CAM_PHASE_OFS:  rd = phase_q;
      `EGC_CAM_IDX_OFS:    rd = {23'h0, tab_idx_q};
      `EGC_CAM_ENTRY_OFS:  rd = tab[tab_idx_q];
      `EGC_CAM_ENGAGE_OFS: rd = eng_pt_q;
      `EGC_CAM_DISENG_OFS: rd = dis_pt_q;
      `EGC_TRIP_REV_OFS:   rd = trip_rev_val_q;
      `EGC_TRIP_FWD_OFS:   rd = trip_fwd_val_q;
      `EGC_STATUS_OFS:     rd = {25'h0, trip_fwd_q, trip_rev_q, dis_armed_q, eng_armed_q, cam_eng_q,
                                 ramping_q, gear_on_q};
      `EGC_SLAVE_REF_OFS:  rd = slave_q;
      `EGC_CAM_MPOS_OFS:   rd = u_q;
      `EGC_CAM_SPOS_OFS:   rd = y_mod;
      default:             rd = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) wb_dat_o <= 32'h0;
    else if (req && !ack_q) wb_dat_o <= rd;
  end

  wb_ack_once_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not a single cycle");
endmodule

// ===== verification/egc_enc_model.sv
// Master axis encoder model: aux encoder and virtual axis counters with a
// free-running servo sample strobe.
// Assumes the bench changes the step only just after a strobe.
`timescale 1ns/10ps
module egc_enc_model (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              use_aux_i,
  input  wire egc_pkg::egc_pos_t step_i,
  output egc_pkg::egc_pos_t      aux_pos_o,
  output egc_pkg::egc_pos_t      virt_pos_o,
  output logic                   tick_o
);
  import egc_pkg::*;
  logic [1:0] cnt_q;
  // ---------------------------------------------------------------------------
  // Sample strobe
  // ---------------------------------------------------------------------------
  // One strobe in four cycles leaves room for bus traffic between samples
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 2'h1;
      tick_o <= (cnt_q == 2'h3);
    end
  end
  // ---------------------------------------------------------------------------
  // Positions
  // ---------------------------------------------------------------------------
  // Position moves with the strobe, so the block sees both at one edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aux_pos_o  <= '0;
      virt_pos_o <= '0;
    end else if (cnt_q == 2'h3) begin
      if (use_aux_i) begin
        aux_pos_o <= aux_pos_o + step_i;
      end else begin
        virt_pos_o <= virt_pos_o + step_i;
      end
    end
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench: Wishbone register tasks plus master motion from the
// encoder model; the slave reference is checked at the ports.
`timescale 1ns/10ps
`include "egc_regs.svh"
module testbench;
  import egc_pkg::*;
  logic        clk, rst_n, cyc, stb, we, ack, lim, stp, asel, tick, hold;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  egc_pos_t    aux, virt, incr, step, sref, r1;
  int          n_errors, n_tests;
  int          tab [4] = '{0, 3000, 2250, 1500};

  egc_top dut (.clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sample_tick_i(tick), .aux_enc_pos_i(aux), .virt_pos_i(virt), .move_incr_i(incr),
    .limit_hit_i(lim), .stop_command_i(stp), .slave_ref_o(sref), .trip_hold_o(hold));
  egc_enc_model enc (.clk_i(clk), .rst_n_i(rst_n), .use_aux_i(asel), .step_i(step),
    .aux_pos_o(aux), .virt_pos_o(virt), .tick_o(tick));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Request held until ack is sampled high, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      results();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic sb(input int b, input logic e);
    bus(1'b0, `EGC_STATUS_OFS, 32'h0);
    check({31'h0, rd[b]}, {31'h0, e});
  endtask
  task automatic hk(input logic e);
    repeat (2) @(posedge clk);
    check({31'h0, hold}, {31'h0, e});
  endtask
  task automatic sync();
    int g;
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (tick !== 1'b1 && g < 10);
    if (tick !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask
  // Step and increment change only right after a sample, so each sample is whole
  task automatic tk(input int n, input egc_pos_t s, input logic a, input egc_pos_t inc);
    sync();
    step <= s;
    asel <= a;
    incr <= inc;
    repeat (n) sync();
    step <= '0;
    incr <= '0;
    repeat (3) sync();
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {cyc, stb, we, lim, stp, asel} = '0;
    adr = '0;
    wdat = '0;
    step = '0;
    incr = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc(`EGC_CTRL_OFS, 32'h0);
    rc(`EGC_CAM_MCYC_OFS, 32'h1);
    rc(`EGC_CAM_INTV_OFS, 32'h1);
    wr(8'hfc, 32'h1234);
    rc(8'hfc, 32'h0);
    check(sref, 32'h0);
    $display("test reset done");
    wr(`EGC_CTRL_OFS, 32'h1);
    wr(`EGC_GEAR_RATIO_OFS, 32'd50000);
    tk(10, 10, 1'b0, 0);
    check(sref, 32'd500);
    tk(10, -4, 1'b0, 0);
    check(sref, 32'd300);
    tk(5, 10, 1'b1, 0);
    check(sref, 32'd300);
    wr(`EGC_GEAR_RATIO_OFS, -32'sd20000);
    tk(4, 5, 1'b0, 0);
    check(sref, 32'd260);
    tk(3, 0, 1'b0, 7);
    check(sref, 32'd281);
    wr(`EGC_CTRL_OFS, 32'h0);
    tk(2, 10, 1'b1, 0);
    check(sref, 32'd241);
    wr(`EGC_GEAR_RATIO_OFS, 32'd2000000);
    rc(`EGC_GEAR_RATIO_OFS, 32'd1279999);
    wr(`EGC_GEAR_RATIO_OFS, -32'sd2000000);
    rc(`EGC_GEAR_RATIO_OFS, -32'sd1279999);
    wr(`EGC_GEAR_RATIO_OFS, 32'd10000);
    wr(`EGC_TRIP_FWD_OFS, 32'd250);
    hk(1'b1);
    tk(2, 5, 1'b1, 0);
    hk(1'b0);
    wr(`EGC_TRIP_REV_OFS, 32'd240);
    hk(1'b1);
    tk(3, -5, 1'b1, 0);
    hk(1'b0);
    $display("test gear done");
    wr(`EGC_CTRL_OFS, 32'h2);
    lim <= 1'b1;
    sb(`EGC_ST_GEAR_ON, 1'b1);
    lim <= 1'b0;
    stp <= 1'b1;
    sb(`EGC_ST_GEAR_ON, 1'b1);
    stp <= 1'b0;
    wr(`EGC_CTRL_OFS, 32'h0);
    stp <= 1'b1;
    sb(`EGC_ST_GEAR_ON, 1'b0);
    stp <= 1'b0;
    wr(`EGC_GEAR_RATIO_OFS, 32'd10000);
    lim <= 1'b1;
    sb(`EGC_ST_GEAR_ON, 1'b0);
    lim <= 1'b0;
    wr(`EGC_CTRL_OFS, 32'h2);
    wr(`EGC_GEAR_RATIO_OFS, 32'd10000);
    sb(`EGC_ST_GEAR_ON, 1'b1);
    wr(`EGC_GEAR_RATIO_OFS, 32'h0);
    sb(`EGC_ST_GEAR_ON, 1'b0);
    $display("test gantry done");
    wr(`EGC_CTRL_OFS, 32'h1);
    wr(`EGC_RAMP_DIST_OFS, 32'd100);
    wr(`EGC_GEAR_RATIO_OFS, 32'd10000);
    tk(1, 10, 1'b0, 0);
    sb(`EGC_ST_RAMPING, 1'b1);
    tk(15, 10, 1'b0, 0);
    sb(`EGC_ST_RAMPING, 1'b0);
    bus(1'b0, `EGC_PHASE_LAG_OFS, 32'h0);
    r1 = rd;
    check(r1, 32'd55);
    tk(5, 10, 1'b0, 0);
    rc(`EGC_PHASE_LAG_OFS, r1);
    $display("test ramp done");
    wr(`EGC_GEAR_RATIO_OFS, 32'h0);
    wr(`EGC_CAM_MCYC_OFS, 32'd9000000);
    rc(`EGC_CAM_MCYC_OFS, 32'h7fffff);
    wr(`EGC_CAM_MCYC_OFS, 32'd6000);
    wr(`EGC_CAM_SCYC_OFS, 32'd1500);
    wr(`EGC_CAM_INTV_OFS, 32'd2000);
    wr(`EGC_CAM_PHASE_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`EGC_CAM_IDX_OFS, i);
      wr(`EGC_CAM_ENTRY_OFS, tab[i]);
    end
    wr(`EGC_CAM_IDX_OFS, 32'd2);
    rc(`EGC_CAM_ENTRY_OFS, 32'd2250);
    wr(`EGC_CAM_IDX_OFS, 32'd300);
    rc(`EGC_CAM_IDX_OFS, 32'd256);
    wr(`EGC_CTRL_OFS, 32'hc);
    // Cam master counts only while the cam is enabled, so it starts at zero
    rc(`EGC_CAM_MPOS_OFS, 32'h0);
    tk(1, 100, 1'b0, 0);
    wr(`EGC_CAM_ENGAGE_OFS, 32'd3000);
    sb(`EGC_ST_ENG_ARMED, 1'b1);
    sb(`EGC_ST_CAM_ENG, 1'b0);
    tk(1, 2900, 1'b0, 0);
    sb(`EGC_ST_CAM_ENG, 1'b1);
    r1 = sref;
    tk(1, 2000, 1'b0, 0);
    check(sref - r1, -32'sd750);
    tk(1, 2000, 1'b0, 0);
    check(sref - r1, 32'd375);
    rc(`EGC_CAM_MPOS_OFS, 32'd1000);
    rc(`EGC_CAM_SPOS_OFS, 32'h0);
    wr(`EGC_CAM_DISENG_OFS, 32'd9000);
    sb(`EGC_ST_CAM_ENG, 1'b0);
    wr(`EGC_CAM_ENGAGE_OFS, -32'sd1);
    sb(`EGC_ST_CAM_ENG, 1'b1);
    wr(`EGC_CAM_DISENG_OFS, 32'd2000);
    sb(`EGC_ST_DIS_ARMED, 1'b1);
    tk(1, 1500, 1'b0, 0);
    sb(`EGC_ST_CAM_ENG, 1'b0);
    wr(`EGC_CAM_ENGAGE_OFS, -32'sd1);
    sb(`EGC_ST_CAM_ENG, 1'b1);
    wr(`EGC_CTRL_OFS, 32'h4);
    sb(`EGC_ST_CAM_ENG, 1'b0);
    $display("test cam done");
    results();
  end
endmodule
